// *** logic/p2g_pkg.sv ***
// constants shared by the port 2 gpio block
`default_nettype none
package p2g_pkg;
   localparam int P2G_W = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] P2G_IDX_CPUIF = 8'h02;
   localparam logic [7:0] P2G_IDX_STAT = 8'h8F;
   localparam logic [7:0] P2G_IDX_DIR = 8'hAF;
   localparam logic [7:0] P2G_IDX_LVL = 8'hCF;
   localparam logic [7:0] P2G_IDX_OUT = 8'hEF;
   // values after reset
   localparam logic [7:0] P2G_DIR_RST = 8'h00;
   localparam logic [7:0] P2G_LVL_RST = 8'hFF;
   localparam logic [7:0] P2G_OUT_RST = 8'h00;
   localparam logic [7:0] P2G_CPUIF_RST = 8'h00;
   localparam logic [1:0] P2G_MODE_RST = 2'h0;
   // field positions
   localparam int P2G_INTSEL_BIT = 0;
   localparam int P2G_STAT_CFG_BIT = 0;
   localparam int P2G_STAT_M16_BIT = 1;
   localparam int P2G_STAT_SEL_BIT = 2;
   localparam int P2G_IRQ_PIN = 6;
   localparam int P2G_STROBE_PIN = 7;
   // host interface mode pin code for the 16-bit multiplexed bus
   localparam logic [1:0] P2G_MODE_MUX16 = 2'h1;
endpackage
`default_nettype wire

// *** logic/p2g_ctl_if.sv ***
// control bundle from the register file to the pin driver
`default_nettype none
interface p2g_ctl_if;
   logic [7:0] dir;
   logic [7:0] latch;
   logic configured;
   logic int_sel;
   logic mode16;
   logic irq_n;
   modport src (output dir, output latch, output configured,
      output int_sel, output mode16, output irq_n);
   modport pad (input dir, input latch, input configured,
      input int_sel, input mode16, input irq_n);
endinterface
`default_nettype wire

// *** logic/p2g_sync.sv ***
// two-flop synchroniser for pin inputs
`default_nettype none
module p2g_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   // first stage is read by the second stage only
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** logic/p2g_pad.sv ***
// per-pin drive, enable and pull-up logic for port 2
`default_nettype none
module p2g_pad
   import p2g_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   p2g_ctl_if.pad ctl,
   output logic [P2G_W-1:0] pin_out,
   output logic [P2G_W-1:0] pin_oe_out,
   output logic [P2G_W-1:0] pullup_out
);
   ////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < P2G_W; i++) begin : g_pin
      logic drv_nxt;
      logic oe_nxt;
      always_comb begin
         drv_nxt = ctl.latch[i];
         oe_nxt = ctl.dir[i];
         if (i == P2G_IRQ_PIN && ctl.int_sel) begin
            // open collector: pull low only while the interrupt is asserted
            drv_nxt = 1'b0;
            oe_nxt = ~ctl.irq_n;
         end else if (i == P2G_STROBE_PIN && ctl.mode16) begin
            // pin belongs to the host strobe, never driven here
            drv_nxt = 1'b0;
            oe_nxt = 1'b0;
         end
      end
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            pin_out[i] <= 1'b0;
            pin_oe_out[i] <= 1'b0;
         end else begin
            pin_out[i] <= drv_nxt;
            pin_oe_out[i] <= oe_nxt;
         end
      end
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            pullup_out[i] <= 1'b1;
         end else begin
            pullup_out[i] <= ~ctl.configured;
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/p2g_top.sv ***
// port 2 gpio block with a classic wishbone register slave
//
// Added by the designer: the Wishbone register port.
`default_nettype none
module p2g_top
   import p2g_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [9:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [1:0] mode_pins_in,
   input wire logic irq_n_in,
   input wire logic [P2G_W-1:0] p2_pin_in,
   output logic [P2G_W-1:0] p2_pin_out,
   output logic [P2G_W-1:0] p2_pin_oe_out,
   output logic [P2G_W-1:0] p2_pullup_out,
   output logic wrh_n_out
);
   ////////////////////////////////////////////////////////////////////
   logic [7:0] dir_r;
   logic [7:0] latch_r;
   logic [7:0] levels_r;
   logic [7:0] cpuif_r;
   logic configured_r;
   logic mode16_r;
   logic [7:0] pin_sync;
   logic [1:0] mode_sync;
   logic [7:0] idx;
   logic req;
   logic wr_go;
   logic [7:0] rd_nxt;

   ////////////////////////////////////////////////////////////////////
   // pins and mode straps come from outside the clock domain
   p2g_sync #(.W(P2G_W), .RST_VAL(P2G_LVL_RST)) u_pin_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in(p2_pin_in),
      .sync_out(pin_sync)
   );

   p2g_sync #(.W(2), .RST_VAL(P2G_MODE_RST)) u_mode_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in(mode_pins_in),
      .sync_out(mode_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // wishbone decode: one word per register, index in address bits 9:2
   assign idx = wb_adr_in[9:2];
   assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   // only lane 0 carries data; a write without it is acked and dropped
   assign wr_go = req & wb_we_in & wb_sel_in[0];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req;
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      case (idx)
         P2G_IDX_DIR: rd_nxt = dir_r;
         P2G_IDX_LVL: rd_nxt = levels_r;
         P2G_IDX_OUT: rd_nxt = latch_r;
         P2G_IDX_CPUIF: rd_nxt = cpuif_r;
         P2G_IDX_STAT: begin
            rd_nxt[P2G_STAT_CFG_BIT] = configured_r;
            rd_nxt[P2G_STAT_M16_BIT] = mode16_r;
            rd_nxt[P2G_STAT_SEL_BIT] = cpuif_r[P2G_INTSEL_BIT];
         end
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (req & ~wb_we_in) begin
         wb_dat_out <= {24'h00_0000, rd_nxt};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // direction register; the first write ends the pull-up phase
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         dir_r <= P2G_DIR_RST;
      end else if (wr_go && idx == P2G_IDX_DIR) begin
         dir_r <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         configured_r <= 1'b0;
      end else if (wr_go && idx == P2G_IDX_DIR) begin
         configured_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         latch_r <= P2G_OUT_RST;
      end else if (wr_go && idx == P2G_IDX_OUT) begin
         latch_r <= wb_dat_in[7:0];
      end
   end

   // only the select bit is kept; the other bits read as zero
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cpuif_r <= P2G_CPUIF_RST;
      end else if (wr_go && idx == P2G_IDX_CPUIF) begin
         cpuif_r[P2G_INTSEL_BIT] <= wb_dat_in[P2G_INTSEL_BIT];
      end
   end

   // the level register has no write path at all
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         levels_r <= P2G_LVL_RST;
      end else begin
         levels_r <= pin_sync;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mode16_r <= 1'b0;
      end else begin
         mode16_r <= (mode_sync == P2G_MODE_MUX16);
      end
   end

   // high-byte write strobe handed to the host interface logic
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wrh_n_out <= 1'b1;
      end else begin
         wrh_n_out <= mode16_r ? pin_sync[P2G_STROBE_PIN] : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   p2g_ctl_if ctl ();
   assign ctl.dir = dir_r;
   assign ctl.latch = latch_r;
   assign ctl.configured = configured_r;
   assign ctl.int_sel = cpuif_r[P2G_INTSEL_BIT];
   assign ctl.mode16 = mode16_r;
   assign ctl.irq_n = irq_n_in;

   p2g_pad u_pad (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ctl(ctl),
      .pin_out(p2_pin_out),
      .pin_oe_out(p2_pin_oe_out),
      .pullup_out(p2_pullup_out)
   );

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   dir_reset_a: assert property (
      $past(rst_in) |-> dir_r == 8'h00 && !configured_r)
      else $error("direction not cleared by reset");

   lvl_reset_a: assert property (
      $past(rst_in) |-> levels_r == 8'hFF)
      else $error("pin level register not all ones after reset");

   latch_reset_a: assert property (
      $past(rst_in) |-> latch_r == 8'h00)
      else $error("output latch not cleared by reset");

   dir_write_a: assert property (
      wr_go && idx == 8'hAF |=> dir_r == $past(wb_dat_in[7:0]))
      else $error("direction write lost");

   latch_write_a: assert property (
      wr_go && idx == 8'hEF |=> ##1
         p2_pin_out[5:0] == $past(wb_dat_in[5:0], 2))
      else $error("latch write not driven on pin");

   lvl_track_a: assert property (
      !$past(rst_in) |-> levels_r == $past(pin_sync))
      else $error("pin level register not tracking pins");

   lvl_nowrite_a: assert property (
      wr_go && idx == 8'hCF |=> $stable(dir_r) && $stable(latch_r)
         && $stable(cpuif_r))
      else $error("write to pin level register changed state");

   dir_oe_a: assert property (
      !$past(rst_in) && !$past(ctl.mode16) && !$past(ctl.int_sel) |->
         p2_pin_oe_out[5:0] == $past(dir_r[5:0]))
      else $error("pin enable does not follow direction");

   pullup_hold_a: assert property (
      !$past(rst_in) |-> p2_pullup_out == {8{~$past(configured_r)}})
      else $error("pull-up state wrong");

   irq_pin_a: assert property (
      $past(ctl.int_sel) && !$past(rst_in) |->
         p2_pin_oe_out[6] == ~$past(irq_n_in) && !p2_pin_out[6])
      else $error("interrupt not routed onto bit 6");

   strobe_pin_a: assert property (
      $past(mode16_r) && !$past(rst_in) |->
         !p2_pin_oe_out[7] && wrh_n_out == $past(pin_sync[7]))
      else $error("bit 7 not handed to host strobe");

   ack_pulse_a: assert property (
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");

   ack_answer_a: assert property (
      req |=> wb_ack_out)
      else $error("request not acknowledged in one cycle");

   ack_cause_a: assert property (
      wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
      else $error("ack without a request");

   dir_read_a: assert property (
      req && !wb_we_in && idx == 8'hAF |=>
         wb_dat_out[7:0] == $past(dir_r))
      else $error("direction register read back wrong");

   lvl_read_a: assert property (
      req && !wb_we_in && idx == 8'hCF |=>
         wb_dat_out[7:0] == $past(levels_r))
      else $error("pin level register read back wrong");

   latch_read_a: assert property (
      req && !wb_we_in && idx == 8'hEF |=>
         wb_dat_out[7:0] == $past(latch_r))
      else $error("output latch read back wrong");

   unmapped_read_a: assert property (
      req && !wb_we_in && idx == 8'h01 |=> wb_dat_out == 32'h0000_0000)
      else $error("unmapped read not zero");

   dat_upper_a: assert property (
      wb_dat_out[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");

   nosel_write_a: assert property (
      req && wb_we_in && !wb_sel_in[0] |=> $stable(dir_r)
         && $stable(latch_r) && $stable(cpuif_r) && $stable(configured_r))
      else $error("write without lane 0 changed state");

   cfg_set_a: assert property (
      wr_go && idx == 8'hAF |=> configured_r)
      else $error("direction write did not end pull-up phase");

   cfg_sticky_a: assert property (
      configured_r |=> configured_r)
      else $error("pull-up phase came back without reset");

   reset_pins_a: assert property (
      $past(rst_in) |-> p2_pullup_out == 8'hFF && p2_pin_oe_out == 8'h00
         && wrh_n_out)
      else $error("pins not released to pull-ups by reset");

   gp_drive_a: assert property (
      !$past(rst_in) |-> p2_pin_out[5:0] == $past(latch_r[5:0]))
      else $error("general pins not driven from latch");

   bit6_gpio_a: assert property (
      !$past(ctl.int_sel) && !$past(rst_in) |->
         p2_pin_oe_out[6] == $past(dir_r[6])
         && p2_pin_out[6] == $past(latch_r[6]))
      else $error("bit 6 not general purpose with select clear");

   bit7_gpio_a: assert property (
      !$past(mode16_r) && !$past(rst_in) |->
         p2_pin_oe_out[7] == $past(dir_r[7]) && wrh_n_out)
      else $error("bit 7 not general purpose outside 16-bit mode");

   cpuif_write_a: assert property (
      wr_go && idx == 8'h02 |=> cpuif_r[0] == $past(wb_dat_in[0]))
      else $error("interrupt pin select write lost");
endmodule
`default_nettype wire

// *** tb/p2g_ext_pins.sv ***
// model of the board circuitry sitting on the port 2 pins
`default_nettype none
module p2g_ext_pins
   import p2g_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [P2G_W-1:0] drv_in,
   input wire logic [P2G_W-1:0] oe_in,
   input wire logic [P2G_W-1:0] pullup_in,
   input wire logic [P2G_W-1:0] ext_en_in,
   input wire logic [P2G_W-1:0] ext_val_in,
   output logic [P2G_W-1:0] level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [P2G_W-1:0] last_r;
   always_ff @(posedge core_clk_in) begin
      last_r <= level_out;
   end
   // an undriven pin without pull-up keeps changing, so no stale level leaks
   always_comb begin
      for (int i = 0; i < P2G_W; i++) begin
         if (oe_in[i]) begin
            level_out[i] = drv_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else if (pullup_in[i]) begin
            level_out[i] = 1'b1;
         end else begin
            level_out[i] = ~last_r[i];
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// register and pin tests for the port 2 gpio block
`default_nettype none
module testbench
   import p2g_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, irq_n = 1;
   logic [9:0] adr = '0;
   logic [31:0] wdat = '0, rdat;
   logic ack, wrh_n;
   logic [1:0] mode = 2'h0;
   logic [3:0] sel = 4'h0;
   logic [7:0] pin_lvl, pin_drv, oe, pu, q;
   logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
   int bad_count = 0, compares = 0, cycles = 0;
   p2g_top u_dut (.core_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .mode_pins_in(mode), .irq_n_in(irq_n), .p2_pin_in(pin_lvl),
      .p2_pin_out(pin_drv), .p2_pin_oe_out(oe), .p2_pullup_out(pu),
      .wrh_n_out(wrh_n));
   p2g_ext_pins u_pins (.core_clk_in(clk), .drv_in(pin_drv), .oe_in(oe),
      .pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val),
      .level_out(pin_lvl));
   initial begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; entered and left just after a rising edge
   task automatic bus(input logic w, input logic [9:0] a,
      input logic [7:0] d, input logic [3:0] s, output logic [7:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h00_0000, d};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         bad_count++;
      end
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'h1, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, q);
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(10'h2BC, 8'h00);
      rd_chk(10'h33C, 8'hFF);
      rd_chk(10'h3BC, 8'h00);
      chk(pu, 8'hFF);
      chk(oe, 8'h00);
      wr(10'h3BC, 8'h65);
      ext_en <= 8'hF0;
      ext_val <= 8'hC0;
      wr(10'h2BC, 8'h0F);
      repeat (4) @(posedge clk);
      chk(oe, 8'h0F);
      chk(pin_drv & 8'h0F, 8'h05);
      chk(pu, 8'h00);
      rd_chk(10'h33C, 8'hC5);
      wr(10'h33C, 8'h00);
      rd_chk(10'h33C, 8'hC5);
      rd_chk(10'h2BC, 8'h0F);
      rd_chk(10'h3BC, 8'h65);
      // a write without byte lane 0 is acknowledged and dropped
      bus(1'b1, 10'h3BC, 8'hAA, 4'h0, q);
      rd_chk(10'h3BC, 8'h65);
      rd_chk(10'h004, 8'h00);
      wr(10'h2BC, 8'h00);
      repeat (4) @(posedge clk);
      chk(oe, 8'h00);
      // host strobe on bit 7 in the 16-bit multiplexed mode
      mode <= P2G_MODE_MUX16;
      ext_en <= 8'h80;
      ext_val <= 8'h00;
      wr(10'h2BC, 8'hFF);
      repeat (6) @(posedge clk);
      chk(oe, 8'h7F);
      chk(wrh_n, 1'b0);
      ext_val <= 8'h80;
      repeat (6) @(posedge clk);
      chk(wrh_n, 1'b1);
      wr(10'h008, 8'h01);
      repeat (4) @(posedge clk);
      chk(oe, 8'h3F);
      irq_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(oe, 8'h7F);
      chk(pin_drv[6], 1'b0);
      rd_chk(10'h23C, 8'h07);
      report_and_stop();
   end
endmodule
`default_nettype wire
